/* File: rtl/mpp_top.sv */
// Memory programming port: serial and parallel programming of flash and EEPROM.
// Assumes all pins are asynchronous to ref_clk; the serial clock is slow.
// How it works
// - Write strobe low pulse starts programming; ready_busy_n low until done.
// - Last loaded command and address stay held across programming operations.
// - EEPROM writes are self-timed and erase the location themselves.
// - Chip erase sets every flash and EEPROM location to all ones.
// - Flash words 0..0x0FFF and EEPROM bytes 0..0x01FF, separate spaces.
// - Serial input sampled on each rising serial clock edge.
// - Read data bits shifted out on falling serial clock edges.
// - When in sync, second unlock byte 0x53 echoes during the third.
// - No serial instruction executes until the unlock frame is seen in sync.
`timescale 1ns/1ps
`default_nettype none

module mpp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("mpp_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;

  assign out_valid = wr_q != rd_q;
  assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module mpp_top #(
  parameter int FIFO_DEPTH   = 16,
  parameter int WRITE_CYCLES = mpp_pkg::WRITE_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       reset_pin_n,
  input  wire logic       sck_pin,
  input  wire logic       mosi_pin,
  output logic            miso_o,
  output logic            miso_oe_n,
  output logic            rx_ready,
  input  wire logic       par_enable,
  input  wire logic       par_load_n,
  input  wire logic       par_wr_n,
  input  wire logic       byte_half_select,
  input  wire logic [1:0] par_sel,
  input  wire logic [7:0] par_data,
  output logic            ready_busy_n
);
  if (WRITE_CYCLES < 1 || WRITE_CYCLES > 4096) begin : g_chk
    $error("mpp_top write time out of range");
  end

  localparam int NS = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [NS-1:0] pins;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;

  assign pins = {par_data, par_sel, byte_half_select, par_wr_n, par_load_n,
                 par_enable, reset_pin_n, mosi_pin};

  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        s1_q[i] <= 1'b1;
        s2_q[i] <= 1'b1;
      end else begin
        s1_q[i] <= pins[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end

  logic sck1_q;
  logic sck2_q;
  logic sck3_q;
  logic ld3_q;
  logic wr3_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sck1_q <= 1'b0;
      sck2_q <= 1'b0;
      sck3_q <= 1'b0;
      ld3_q  <= 1'b1;
      wr3_q  <= 1'b1;
    end else begin
      sck1_q <= sck_pin;
      sck2_q <= sck1_q;
      sck3_q <= sck2_q;
      ld3_q  <= s2_q[3];
      wr3_q  <= s2_q[4];
    end
  end

  logic       mosi_s;
  logic       bhs_s;
  logic [1:0] sel_s;
  logic [7:0] pdata_s;
  logic       sck_rise;
  logic       sck_fall;
  logic       ld_fall;
  logic       wr_fall;
  logic       ser_act;
  logic       par_act;

  assign mosi_s   = s2_q[0];
  assign bhs_s    = s2_q[5];
  assign sel_s    = s2_q[7:6];
  assign pdata_s  = s2_q[15:8];
  assign sck_rise = sck2_q && !sck3_q;
  assign sck_fall = !sck2_q && sck3_q;
  assign ld_fall  = !s2_q[3] && ld3_q;
  assign wr_fall  = !s2_q[4] && wr3_q;
  assign ser_act  = !s2_q[1] && !s2_q[2];
  assign par_act  = !s2_q[1] && s2_q[2];

  //////////////////////////////////////////////////////////////////////////////
  // Memories

  logic [15:0] flash_q [mpp_pkg::FLASH_WORDS];
  logic [7:0]  ee_q    [mpp_pkg::EE_BYTES];

  function automatic mpp_pkg::mpp_kind_t ser_kind(input logic [7:0] op,
                                                  input logic [7:0] sub);
    ser_kind = mpp_pkg::K_NONE;
    if (op == mpp_pkg::OP_WR_FLO) ser_kind = mpp_pkg::K_FLO;
    if (op == mpp_pkg::OP_WR_FHI) ser_kind = mpp_pkg::K_FHI;
    if (op == mpp_pkg::OP_WR_EE)  ser_kind = mpp_pkg::K_EE;
    if (op == mpp_pkg::OP_ENABLE && sub == mpp_pkg::SUB_ERASE) begin
      ser_kind = mpp_pkg::K_ERASE;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Serial receive, echo and read-back

  logic [2:0]  bit_q;
  logic [1:0]  idx_q;
  logic [6:0]  sh_q;
  logic [7:0]  b0_q;
  logic [7:0]  b1_q;
  logic [7:0]  b2_q;
  logic [7:0]  tx_q;
  logic [7:0]  last_q;
  logic        en_q;
  logic [7:0]  byte_new;
  logic [7:0]  rd_byte;
  logic        frame_end;
  logic        push;
  logic [31:0] push_word;

  assign byte_new  = {sh_q, mosi_s};
  assign frame_end = sck_rise && bit_q == 3'h7 && idx_q == 2'h3;
  assign push_word = {b0_q, b1_q, b2_q, byte_new};
  assign push      = frame_end && en_q && ser_kind(b0_q, b1_q) != mpp_pkg::K_NONE;

  // Read data must be ready before the fourth byte, so look up at byte three
  always_comb begin
    rd_byte = b1_q;
    if (en_q) begin
      unique case (b0_q)
        mpp_pkg::OP_RD_FLO: rd_byte = flash_q[{b1_q[3:0], byte_new}][7:0];
        mpp_pkg::OP_RD_FHI: rd_byte = flash_q[{b1_q[3:0], byte_new}][15:8];
        mpp_pkg::OP_RD_EE:  rd_byte = ee_q[{b1_q[0], byte_new}];
        default:            rd_byte = b1_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !ser_act) begin
      bit_q <= 3'h0;
      idx_q <= 2'h0;
      sh_q  <= 7'h00;
      b0_q  <= 8'h00;
      b1_q  <= 8'h00;
      b2_q  <= 8'h00;
      tx_q  <= 8'h00;
      last_q <= 8'h00;
    end else if (sck_rise) begin
      sh_q  <= byte_new[6:0];
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        idx_q <= idx_q + 2'h1;
        // Echo of the byte just taken; 0x53 comes back during the third
        tx_q   <= byte_new;
        last_q <= byte_new;
        // Unlock pattern on any byte boundary realigns the frame while locked, so a bit slip costs a few retries,
        // but a bit-shifted frame can still echo 0x53 in its third byte with no unlock
        if (!en_q && last_q == mpp_pkg::OP_ENABLE
            && byte_new == mpp_pkg::SUB_ENABLE) begin
          idx_q <= 2'h2;
          b0_q  <= last_q;
          b1_q  <= byte_new;
        end else begin
          unique case (idx_q)
            2'h0: b0_q <= byte_new;
            2'h1: b1_q <= byte_new;
            2'h2: begin
              b2_q <= byte_new;
              tx_q <= rd_byte;
            end
            2'h3: b0_q <= b0_q;
          endcase
        end
      end
    end
  end

  // Unlock only when the frame lines up; a stray bit keeps it locked
  always_ff @(posedge ref_clk) begin
    if (rst || !ser_act) begin
      en_q <= 1'b0;
    end else if (frame_end && b0_q == mpp_pkg::OP_ENABLE
                 && b1_q == mpp_pkg::SUB_ENABLE) begin
      en_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !ser_act) begin
      miso_o    <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= 1'b0;
      if (sck_fall) begin
        miso_o <= tx_q[~bit_q];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction queue between serial link and write engine

  logic        q_valid;
  logic        q_ready;
  logic [31:0] q_word;

  mpp_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .rst       (rst || !ser_act),
    .in_valid  (push),
    .in_ready  (rx_ready),
    .in_data   (push_word),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Parallel command, address and data latches

  logic [7:0]  pcmd_q;
  logic [11:0] paddr_q;
  logic [15:0] pdat_q;

  // Never cleared by programming, so one command load serves many locations
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pcmd_q  <= 8'h00;
      paddr_q <= 12'h000;
      pdat_q  <= 16'hFFFF;
    end else if (par_act && ld_fall) begin
      unique case (sel_s)
        mpp_pkg::SEL_ADDR: begin
          if (bhs_s) paddr_q[11:8] <= pdata_s[3:0];
          else       paddr_q[7:0]  <= pdata_s;
        end
        mpp_pkg::SEL_DATA: begin
          if (bhs_s) pdat_q[15:8] <= pdata_s;
          else       pdat_q[7:0]  <= pdata_s;
        end
        mpp_pkg::SEL_CMD: pcmd_q <= pdata_s;
        default:          pcmd_q <= pcmd_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write engine

  mpp_pkg::mpp_state_t state_q;
  mpp_pkg::mpp_kind_t  kind_q;
  mpp_pkg::mpp_kind_t  par_kind;
  logic [11:0]         addr_q;
  logic [7:0]          data_q;
  logic [12:0]         cnt_q;
  logic                par_go;
  logic                take;

  always_comb begin
    par_kind = mpp_pkg::K_NONE;
    if (pcmd_q == mpp_pkg::PCMD_ERASE) par_kind = mpp_pkg::K_ERASE;
    if (pcmd_q == mpp_pkg::PCMD_EE)    par_kind = mpp_pkg::K_EE;
    if (pcmd_q == mpp_pkg::PCMD_FLASH) begin
      par_kind = bhs_s ? mpp_pkg::K_FHI : mpp_pkg::K_FLO;
    end
  end

  assign par_go       = par_act && wr_fall && state_q == mpp_pkg::S_IDLE
                        && par_kind != mpp_pkg::K_NONE;
  assign q_ready      = state_q == mpp_pkg::S_IDLE && !par_go;
  assign take         = q_valid && q_ready;
  assign ready_busy_n = state_q == mpp_pkg::S_IDLE;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= mpp_pkg::S_IDLE;
      kind_q  <= mpp_pkg::K_NONE;
      addr_q  <= 12'h000;
      data_q  <= 8'h00;
      cnt_q   <= 13'h0000;
    end else begin
      unique case (state_q)
        mpp_pkg::S_IDLE: begin
          cnt_q <= 13'h0000;
          if (par_go) begin
            kind_q  <= par_kind;
            addr_q  <= paddr_q;
            data_q  <= bhs_s ? pdat_q[15:8] : pdat_q[7:0];
            state_q <= par_kind == mpp_pkg::K_ERASE ? mpp_pkg::S_ERASE
                                                    : mpp_pkg::S_WRITE;
          end else if (take) begin
            kind_q  <= ser_kind(q_word[31:24], q_word[23:16]);
            addr_q  <= {q_word[19:16], q_word[15:8]};
            data_q  <= q_word[7:0];
            state_q <= ser_kind(q_word[31:24], q_word[23:16]) == mpp_pkg::K_ERASE
                       ? mpp_pkg::S_ERASE : mpp_pkg::S_WRITE;
          end
        end
        mpp_pkg::S_WRITE: begin
          cnt_q <= cnt_q + 13'h0001;
          if (cnt_q == 13'(WRITE_CYCLES - 1)) begin
            state_q <= mpp_pkg::S_IDLE;
          end
        end
        mpp_pkg::S_ERASE: begin
          cnt_q <= cnt_q + 13'h0001;
          if (cnt_q == 13'(mpp_pkg::FLASH_WORDS - 1)) begin
            state_q <= mpp_pkg::S_IDLE;
          end
        end
        default: state_q <= mpp_pkg::S_IDLE;
      endcase
    end
  end

  // Commit at the end of the timed write; EEPROM overwrite needs no erase
  always_ff @(posedge ref_clk) begin
    if (state_q == mpp_pkg::S_WRITE && cnt_q == 13'(WRITE_CYCLES - 1)) begin
      unique case (kind_q)
        mpp_pkg::K_FLO: flash_q[addr_q][7:0]  <= data_q;
        mpp_pkg::K_FHI: flash_q[addr_q][15:8] <= data_q;
        mpp_pkg::K_EE:  ee_q[addr_q[8:0]]     <= data_q;
        default:        ;
      endcase
    end
    if (state_q == mpp_pkg::S_ERASE) begin
      flash_q[cnt_q[11:0]] <= {mpp_pkg::ERASED_BYTE, mpp_pkg::ERASED_BYTE};
      if (cnt_q < 13'(mpp_pkg::EE_BYTES)) begin
        ee_q[cnt_q[8:0]] <= mpp_pkg::ERASED_BYTE;
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/mpp_pkg.sv */
// Constants and types of the memory programming port.
// Assumes a single 50 MHz clock that also stands in for the oscillator pin.
package mpp_pkg;

  localparam int FLASH_AW    = 12;
  localparam int FLASH_WORDS = 4096;
  localparam int EE_AW       = 9;
  localparam int EE_BYTES    = 512;

  // Serial instruction bytes
  localparam logic [7:0] OP_ENABLE   = 8'hAC;
  localparam logic [7:0] SUB_ENABLE  = 8'h53;
  localparam logic [7:0] SUB_ERASE   = 8'h80;
  localparam logic [7:0] OP_RD_FLO   = 8'h20;
  localparam logic [7:0] OP_RD_FHI   = 8'h28;
  localparam logic [7:0] OP_WR_FLO   = 8'h40;
  localparam logic [7:0] OP_WR_FHI   = 8'h48;
  localparam logic [7:0] OP_RD_EE    = 8'hA0;
  localparam logic [7:0] OP_WR_EE    = 8'hC0;

  // Parallel commands and load targets
  localparam logic [7:0] PCMD_ERASE  = 8'h80;
  localparam logic [7:0] PCMD_FLASH  = 8'h10;
  localparam logic [7:0] PCMD_EE     = 8'h11;
  localparam logic [1:0] SEL_ADDR    = 2'h0;
  localparam logic [1:0] SEL_DATA    = 2'h1;
  localparam logic [1:0] SEL_CMD     = 2'h2;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  localparam int CLK_PERIOD_NS = 20;
  localparam int WRITE_TIME_NS = 4000;
  localparam int WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {K_NONE, K_FLO, K_FHI, K_EE, K_ERASE} mpp_kind_t;
  typedef enum logic [1:0] {S_IDLE, S_WRITE, S_ERASE} mpp_state_t;

endpackage

/* File: tb/mpp_top_props.sv */
// Checker for the memory programming port, bound to mpp_top.
// Assumes a serial clock half period of about four ref_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module mpp_top_props #(
  parameter int FIFO_DEPTH   = 16,
  parameter int WRITE_CYCLES = 200
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       reset_pin_n,
  input wire logic       sck_pin,
  input wire logic       mosi_pin,
  input wire logic       miso_o,
  input wire logic       miso_oe_n,
  input wire logic       rx_ready,
  input wire logic       par_enable,
  input wire logic       par_load_n,
  input wire logic       par_wr_n,
  input wire logic       byte_half_select,
  input wire logic [1:0] par_sel,
  input wire logic [7:0] par_data,
  input wire logic       ready_busy_n
);
  localparam int ERASE_CYCLES = 4096;
  logic [12:0] busy_cnt_q;
  logic [3:0]  age_q;
  logic        sck_q;
////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst || ready_busy_n) begin
      busy_cnt_q <= 13'h0000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 13'h0001;
    end
  end
  // Cycles since the serial clock fell, saturating
  always_ff @(posedge ref_clk) begin
    sck_q <= sck_pin;
    if (rst) begin
      age_q <= 4'hF;
    end else if (sck_q && !sck_pin) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hF) begin
      age_q <= age_q + 4'h1;
    end
  end
////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence pin_released_s; reset_pin_n [*8]; endsequence
  sequence par_held_s; par_enable [*8]; endsequence
  sequence sck_high_s; sck_pin [*4]; endsequence

  serial_off_a: assert property (pin_released_s |-> miso_oe_n)
    else $error("miso driven outside the programming window");
  par_mode_a: assert property (par_held_s |-> miso_oe_n)
    else $error("miso driven in parallel mode");
  window_close_a: assert property (pin_released_s |=> !$fell(ready_busy_n))
    else $error("programming started with reset pin released");
  busy_len_a: assert property (($rose(ready_busy_n) && !$past(rst)) |->
    (int'(busy_cnt_q) == WRITE_CYCLES || int'(busy_cnt_q) == ERASE_CYCLES))
    else $error("busy period has a wrong length");
  busy_max_a: assert property (busy_cnt_q <= 13'h1000)
    else $error("busy period too long");
  busy_hold_a: assert property ($fell(ready_busy_n) |-> !ready_busy_n [*4])
    else $error("busy pulse too short");
  miso_shift_a: assert property ((!$past(rst) && $changed(miso_o) && !miso_oe_n &&
    !$past(miso_oe_n)) |-> age_q inside {[4'h1:4'h5]})
    else $error("miso changed away from a serial clock fall");
  miso_hold_a: assert property (sck_high_s |-> (miso_oe_n || $stable(miso_o)))
    else $error("miso changed while serial clock high");
endmodule

bind mpp_top mpp_top_props #(
  .FIFO_DEPTH  (FIFO_DEPTH),
  .WRITE_CYCLES(WRITE_CYCLES)
) i_props (
  .ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n), .sck_pin(sck_pin),
  .mosi_pin(mosi_pin), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .rx_ready(rx_ready),
  .par_enable(par_enable), .par_load_n(par_load_n), .par_wr_n(par_wr_n),
  .byte_half_select(byte_half_select), .par_sel(par_sel), .par_data(par_data),
  .ready_busy_n(ready_busy_n)
);
`default_nettype wire

/* File: tb/mpp_prog_model.sv */
// Behavioural serial programmer on the device's serial pins.
// Assumes the bench opens the programming window before frames count.
`timescale 1ns/1ps
`default_nettype none
module mpp_prog_model #(
  parameter int HALF_NS    = 80,
  parameter int POWERUP_NS = 2000
) (
  output logic      sck_pin,
  output logic      mosi_pin,
  input  wire logic miso_o,
  input  wire logic miso_oe_n
);
  logic seen_q;
  initial begin
    sck_pin  = 1'b0;
    mosi_pin = 1'b1;
    seen_q   = 1'b0;
  end
  // Settle time shortened to keep the run brief
  task automatic power_up();
    sck_pin = 1'b0;
    #POWERUP_NS;
  endtask
  task automatic pulse();
    #HALF_NS sck_pin = 1'b1;
    #HALF_NS sck_pin = 1'b0;
  endtask
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      mosi_pin = tx[i];
      #HALF_NS sck_pin = 1'b1;
      #(HALF_NS - 1);
      // Undriven line shows the inverse of the last bit
      seen_q = miso_oe_n ? ~seen_q : miso_o;
      rx[i] = seen_q;
      #1 sck_pin = 1'b0;
    end
    mosi_pin = ~mosi_pin;
    #(4 * HALF_NS);
  endtask
  task automatic unlock(input int tries, output logic ok, output int n);
    logic [31:0] rx;
    ok = 1'b0;
    n  = 0;
    while (!ok && n < tries) begin
      n++;
      frame({mpp_pkg::OP_ENABLE, mpp_pkg::SUB_ENABLE, 16'h0000}, rx);
      ok = (rx[15:8] === mpp_pkg::SUB_ENABLE);
      if (!ok) begin
        pulse();
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/mpp_top_tb.sv */
// Self-checking bench for mpp_top with a serial programmer model.
// Assumes a 50 MHz ref_clk and a slow write time for buffer filling.
`timescale 1ns/1ps
`default_nettype none
module mpp_top_tb;
  localparam int WC = 1000;
  localparam logic [7:0] WOP [6] = '{mpp_pkg::OP_WR_EE, mpp_pkg::OP_WR_EE, mpp_pkg::OP_WR_FLO,
    mpp_pkg::OP_WR_FLO, mpp_pkg::OP_WR_FHI, mpp_pkg::OP_WR_EE};
  localparam logic [7:0] ROP [6] = '{mpp_pkg::OP_RD_EE, mpp_pkg::OP_RD_EE, mpp_pkg::OP_RD_FLO,
    mpp_pkg::OP_RD_FLO, mpp_pkg::OP_RD_FHI, mpp_pkg::OP_RD_EE};
  localparam logic [11:0] ADR [6] = '{12'h1FF, 12'h000, 12'hFFF, 12'h000, 12'h000, 12'h1FF};
  localparam logic [7:0] DAT [6] = '{8'h5A, 8'hA5, 8'hC3, 8'h3C, 8'h69, 8'h12};
  logic       ref_clk, rst, reset_pin_n, sck_pin, mosi_pin, miso_o, miso_oe_n, rx_ready;
  logic       par_enable, par_load_n, par_wr_n, byte_half_select, ready_busy_n;
  logic [1:0] par_sel;
  logic [7:0] par_data;
  int         num_errors, check_count;

  mpp_top #(.FIFO_DEPTH(16), .WRITE_CYCLES(WC)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n), .sck_pin(sck_pin),
    .mosi_pin(mosi_pin), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .rx_ready(rx_ready),
    .par_enable(par_enable), .par_load_n(par_load_n), .par_wr_n(par_wr_n),
    .byte_half_select(byte_half_select), .par_sel(par_sel), .par_data(par_data),
    .ready_busy_n(ready_busy_n));
  mpp_prog_model #(.HALF_NS(80), .POWERUP_NS(2000)) i_prog (
    .sck_pin(sck_pin), .mosi_pin(mosi_pin), .miso_o(miso_o), .miso_oe_n(miso_oe_n));
////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask
  task automatic wait_busy();
    int i;
    i = 0;
    tick(4);
    check("busy", 8'(ready_busy_n), 8'h00);
    while (ready_busy_n !== 1'b1 && i < 6000) begin
      tick(1);
      i++;
    end
    check("done", 8'(ready_busy_n), 8'h01);
  endtask
  task automatic ser(input logic [7:0] op, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [31:0] r;
    tick(1);
    i_prog.frame({op, 4'h0, a, d}, r);
    q = r[7:0];
  endtask
  task automatic pload(input logic [1:0] s, input logic h, input logic [7:0] d);
    par_sel = s;
    byte_half_select = h;
    par_data = d;
    tick(3);
    par_load_n = 1'b0;
    tick(4);
    par_load_n = 1'b1;
    tick(4);
  endtask
  task automatic pwrite();
    byte_half_select = 1'b1;
    tick(3);
    par_wr_n = 1'b0;
    tick(4);
    par_wr_n = 1'b1;
    tick(4);
    // Strobe while busy must not stretch the busy period
    par_wr_n = 1'b0;
    tick(4);
    par_wr_n = 1'b1;
    wait_busy();
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic t_open();
    logic ok;
    int   n;
    check("oe reset", 8'(miso_oe_n), 8'h01);
    check("ready reset", 8'(ready_busy_n), 8'h01);
    i_prog.unlock(1, ok, n);
    check("closed echo", 8'(ok), 8'h00);
    i_prog.power_up();
    tick(1);
    reset_pin_n = 1'b0;
    tick(6);
    check("oe open", 8'(miso_oe_n), 8'h00);
    i_prog.pulse();
    i_prog.unlock(32, ok, n);
    check("resync", 8'(ok), 8'h01);
    check("retried", 8'(n > 1), 8'h01);
    $display("window and unlock done");
  endtask
  task automatic t_rw();
    logic [7:0] q;
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      ser(WOP[i], ADR[i], DAT[i], q);
      wait_busy();
    end
    for (int i = 1; i < 6; i++) begin
      ser(ROP[i], ADR[i], 8'h00, q);
      check("read", q, DAT[i]);
    end
    tick(1);
    i_prog.frame({mpp_pkg::OP_ENABLE, mpp_pkg::SUB_ERASE, 16'h0000}, r);
    wait_busy();
    for (int i = 1; i < 6; i++) begin
      ser(ROP[i], ADR[i], 8'h00, q);
      check("erased", q, mpp_pkg::ERASED_BYTE);
    end
    $display("serial write, read and erase done");
  endtask
  task automatic t_par();
    logic [7:0] q;
    logic       ok;
    int         n;
    par_enable = 1'b1;
    tick(8);
    pload(mpp_pkg::SEL_CMD, 1'b0, mpp_pkg::PCMD_FLASH);
    pload(mpp_pkg::SEL_ADDR, 1'b0, 8'h23);
    pload(mpp_pkg::SEL_ADDR, 1'b1, 8'h01);
    pload(mpp_pkg::SEL_DATA, 1'b1, 8'hA5);
    pwrite();
    pload(mpp_pkg::SEL_ADDR, 1'b0, 8'h24);
    pload(mpp_pkg::SEL_DATA, 1'b1, 8'h96);
    pwrite();
    pload(mpp_pkg::SEL_CMD, 1'b0, mpp_pkg::PCMD_EE);
    pload(mpp_pkg::SEL_ADDR, 1'b0, 8'h05);
    pload(mpp_pkg::SEL_DATA, 1'b1, 8'h77);
    pwrite();
    par_enable = 1'b0;
    tick(8);
    i_prog.unlock(32, ok, n);
    check("relock", 8'(ok), 8'h01);
    ser(mpp_pkg::OP_RD_FHI, 12'h123, 8'h00, q);
    check("par high", q, 8'hA5);
    ser(mpp_pkg::OP_RD_FHI, 12'h124, 8'h00, q);
    check("kept cmd", q, 8'h96);
    ser(mpp_pkg::OP_RD_FLO, 12'h123, 8'h00, q);
    check("low kept", q, mpp_pkg::ERASED_BYTE);
    ser(mpp_pkg::OP_RD_EE, 12'h105, 8'h00, q);
    check("par eeprom", q, 8'h77);
    $display("parallel write done");
  endtask
  task automatic t_fill();
    logic [7:0] q;
    logic       full;
    int         i, k;
    full = 1'b0;
    i = 0;
    while (!full && i < 40) begin
      ser(mpp_pkg::OP_WR_EE, 12'(i), 8'h30 + 8'(i), q);
      full = (rx_ready === 1'b0);
      i++;
    end
    check("full", 8'(full), 8'h01);
    k = 0;
    i = 0;
    while (k < 20 && i < 30000) begin
      tick(1);
      i++;
      k = (ready_busy_n === 1'b1) ? k + 1 : 0;
    end
    check("drain time", 8'(k >= 20), 8'h01);
    check("drained", 8'(rx_ready), 8'h01);
    ser(mpp_pkg::OP_RD_EE, 12'h000, 8'h00, q);
    check("first", q, 8'h30);
    $display("buffer fill done");
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    par_enable = 1'b0;
    par_load_n = 1'b1;
    par_wr_n = 1'b1;
    byte_half_select = 1'b0;
    par_sel = mpp_pkg::SEL_ADDR;
    par_data = 8'h00;
    num_errors = 0;
    check_count = 0;
    repeat (5) @(posedge ref_clk);
    #2 rst = 1'b0;
    tick(4);
    t_open();
    t_rw();
    t_par();
    t_fill();
    give_verdict();
  end
  initial begin
    #2_000_000;
    num_errors++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
`default_nettype wire
